// File: rtl/sarctl_core.sv
/*
  Converter control: conversion start, busy, self-clearing reset on
  select or start activity during a conversion, power-up trim reads
  and the three-state parallel result port.
  Assumes the host strobes are asynchronous pins; the analog result
  arrives as a level on sample_i at conversion end.
*/
// Overview of operation
// - Start low with select low begins conversion
// - Busy high during conversion, low at end
// - Drive data only when select and read low
// - Start falling mid-conversion with select low resets
// - Select falling mid-conversion also resets
// - Internal reset clears itself, no reset pin
// - Reset completion clears output latches to zero
// - Internal reset forces busy low
// - New acquisition begins at following busy fall
// - Early conversions: up to three results invalid until trim loads
// - Initialization reads load factory trim
`timescale 1ns/1ps
`default_nettype none
module sarctl_core
  import sarctl_pkg::*;
(
  input  wire logic                            clk_i,          // 20 MHz clock
  input  wire logic                            reset_i,        // Async reset, active high
  input  wire logic                            conversion_start_n_i, // Start strobe pin, low active
  input  wire logic                            cs_n_i,         // Chip select pin, low active
  input  wire logic                            rd_n_i,         // Read strobe pin, low active
  input  wire logic [sarctl_pkg::DATA_W-1:0]   sample_i,       // Result from analog core
  output logic                                 busy_o,         // Conversion running
  output logic                                 acq_o,          // Acquisition phase
  output logic                                 trim_ok_o,      // Trim loaded
  output logic [sarctl_pkg::DATA_W-1:0]        data_o,         // Parallel data out
  output logic                                 data_oe_n_o     // Data enable, low drives
);
  import sarctl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [2:0]    pins_s;                         // {start, select, read} synced
  logic          st_n_s, cs_n_s, rd_n_s;         // Individual synced pins
  logic          st_n_q, cs_n_q, rd_n_q;         // Previous synced values
  logic          st_fall, cs_fall, rd_rise;      // One-cycle edges

  sarctl_sync #(.W(3), .IDLE(3'b111)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   ({conversion_start_n_i, cs_n_i, rd_n_i}),
    .sync_o  (pins_s)
  );

  assign st_n_s  = pins_s[2];
  assign cs_n_s  = pins_s[1];
  assign rd_n_s  = pins_s[0];
  assign st_fall = st_n_q & ~st_n_s;
  assign cs_fall = cs_n_q & ~cs_n_s;
  assign rd_rise = ~rd_n_q & rd_n_s;

  // Edge history, idle high so reset never fakes an edge
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_n_q <= 1'b1;
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      st_n_q <= st_n_s;
      cs_n_q <= cs_n_s;
      rd_n_q <= rd_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Start qualification
  // ----------------------------------------------------------------
  logic [7:0]    low_cnt_q;                      // Cycles start held low
  logic          start_ok;                       // Pulse wide enough

  // Count how long start stays low with select low
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_cnt_q <= CNT_RST;
    end else if (st_n_s || cs_n_s) begin
      low_cnt_q <= CNT_RST;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  // Synchroniser latency already exceeds 40 ns, so one sampled low suffices
  assign start_ok = (low_cnt_q == 8'(START_LOW_CYC - 1)) & ~st_n_s & ~cs_n_s;

  // ----------------------------------------------------------------
  // Control state machine
  // ----------------------------------------------------------------
  sarctl_state_t state_q;                        // Current state
  logic [7:0]    conv_cnt_q;                     // Conversion cycle count
  logic          abort;                          // Reset trigger during conversion
  logic          conv_done;                      // Conversion finishing

  assign abort     = (state_q == SARCTL_CONV) &&
                     ((st_fall && !cs_n_s) || cs_fall);
  assign conv_done = (state_q == SARCTL_CONV) && !abort &&
                     (conv_cnt_q == 8'(CONV_CYC - 1));

  // State advance; reset state lasts a single cycle then leaves by itself
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= SARCTL_IDLE;
    end else begin
      case (state_q)
        SARCTL_IDLE: begin
          if (start_ok) state_q <= SARCTL_CONV;
        end
        SARCTL_CONV: begin
          if (abort) state_q <= SARCTL_RESET;
          else if (conv_done) state_q <= SARCTL_IDLE;
        end
        SARCTL_RESET: begin
          state_q <= SARCTL_IDLE;
        end
        default: begin
          state_q <= SARCTL_IDLE;                                    // Recover from bad code
        end
      endcase
    end
  end

  // Conversion length counter
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_cnt_q <= CNT_RST;
    end else if (state_q != SARCTL_CONV) begin
      conv_cnt_q <= CNT_RST;
    end else begin
      conv_cnt_q <= conv_cnt_q + 8'h01;
    end
  end

  // Busy tracks the conversion; abort drops it at once
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else if (abort || conv_done) begin
      busy_o <= 1'b0;
    end else if (state_q == SARCTL_IDLE && start_ok) begin
      busy_o <= 1'b1;
    end
  end

  // Acquisition restarts on the busy fall, including after an abort
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acq_o <= 1'b1;
    end else if (abort || conv_done) begin
      acq_o <= 1'b1;
    end else if (state_q == SARCTL_IDLE && start_ok) begin
      acq_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-up trim loading
  // ----------------------------------------------------------------
  logic [1:0]    rd_cnt_q;                       // Completed read cycles
  logic [1:0]    spoil_cnt_q;                    // Spoiled conversions so far

  // Each read rising edge completes one cycle; stops at three
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_cnt_q  <= RD_CNT_RST;
      trim_ok_o <= 1'b0;
    end else if (!trim_ok_o && rd_rise) begin
      rd_cnt_q  <= rd_cnt_q + 2'h1;
      trim_ok_o <= (rd_cnt_q == 2'(INIT_READS - 1));
    end
  end

  // Conversions finished before trim are counted, up to three
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      spoil_cnt_q <= RD_CNT_RST;
    end else if (conv_done && !trim_ok_o && spoil_cnt_q != 2'(SPOIL_CONVS)) begin
      spoil_cnt_q <= spoil_cnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Output latch and three-state control
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] result_q;                   // Latched result

  // Abort clears latch; only a finished conversion loads it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_q <= DATA_RST;
    end else if (state_q == SARCTL_RESET) begin
      result_q <= DATA_RST;
    end else if (conv_done) begin
      // Untrimmed converter gives garbage for the first three results
      result_q <= (!trim_ok_o && spoil_cnt_q != 2'(SPOIL_CONVS)) ?
                  DATA_BAD : sample_i;
    end
  end

  // Pins driven only when select and read are both low
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_o      <= DATA_RST;
      data_oe_n_o <= 1'b1;
    end else begin
      data_o      <= result_q;
      data_oe_n_o <= cs_n_s | rd_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ABORT_DROPS_BUSY: assert property (@(posedge clk_i) disable iff (reset_i)
    abort |=> !busy_o && state_q == SARCTL_RESET)
    else $error("Busy not dropped on internal reset");
  AST_RESET_SELF_CLEARS: assert property (@(posedge clk_i) disable iff (reset_i)
    state_q == SARCTL_RESET |=> state_q == SARCTL_IDLE)
    else $error("Internal reset did not release");
  AST_LATCH_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    state_q == SARCTL_RESET |=> result_q == DATA_RST ##1 data_o == DATA_RST)
    else $error("Latch not cleared by internal reset");
  AST_START_BUSY: assert property (@(posedge clk_i) disable iff (reset_i)
    state_q == SARCTL_IDLE && start_ok |=> busy_o && !acq_o)
    else $error("Start did not raise busy");
  AST_BUSY_LENGTH: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(busy_o) |-> busy_o throughout (##[1:29] (!busy_o || abort || conv_done)))
    else $error("Busy fell early");
  AST_DRIVE_GATE: assert property (@(posedge clk_i) disable iff (reset_i)
    !data_oe_n_o |-> !$past(cs_n_s) && !$past(rd_n_s))
    else $error("Data driven without select and read");
  AST_SELECT_ABORT: assert property (@(posedge clk_i) disable iff (reset_i)
    state_q == SARCTL_CONV && cs_fall |=> state_q == SARCTL_RESET)
    else $error("Select fall did not reset");
  AST_ACQ_AFTER_ABORT: assert property (@(posedge clk_i) disable iff (reset_i)
    abort |=> acq_o && $fell(busy_o))
    else $error("Acquisition not restarted");
  AST_TRIM_AFTER_THREE: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(trim_ok_o) |-> $past(rd_cnt_q) == 2'h2)
    else $error("Trim flag on wrong read count");
  AST_UNTRIMMED_BAD: assert property (@(posedge clk_i) disable iff (reset_i)
    conv_done && !trim_ok_o && spoil_cnt_q == 2'h0 |=> result_q == DATA_BAD)
    else $error("Untrimmed result not marked invalid");

endmodule : sarctl_core
`default_nettype wire

// File: rtl/sarctl_pkg.sv
/*
  Shared constants for the converter control block: timing counts,
  data width and reset values.
  Assumes a single 20 MHz system clock drives every file that imports it.
*/
package sarctl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;   // System clock rate
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ; // 50 ns
  localparam int unsigned START_LOW_NS    = 40;            // Least start-pulse width
  // Least time rounds up, and never below one cycle
  localparam int unsigned START_LOW_CYC_RAW = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_LOW_CYC   = (START_LOW_CYC_RAW < 1) ? 1 : START_LOW_CYC_RAW;
  localparam int unsigned CONV_CYC        = 30;            // Conversion length in cycles
  localparam int unsigned INIT_READS      = 3;             // Reads needed after power-up
  localparam int unsigned SPOIL_CONVS     = 3;             // Conversions spoiled before trim

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W          = 18;            // Result width
  localparam logic [17:0] DATA_RST        = 18'h0_0000;    // Latches after reset
  localparam logic [17:0] DATA_BAD        = 18'h3_FFFF;    // Marker for untrimmed result
  localparam logic [7:0]  CNT_RST         = 8'h00;         // Counter reset value
  localparam logic [1:0]  RD_CNT_RST      = 2'h0;          // Read counter reset value

  // ----------------------------------------------------------------
  // Control states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SARCTL_IDLE  = 3'b001,   // Acquiring, waiting for a start
    SARCTL_CONV  = 3'b010,   // Conversion running
    SARCTL_RESET = 3'b100    // Self-clearing internal reset
  } sarctl_state_t;

endpackage : sarctl_pkg

// File: rtl/sarctl_sync.sv
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes inputs are asynchronous to clk_i; reset forces a chosen idle level.
*/
`timescale 1ns/1ps
`default_nettype none
module sarctl_sync #(
  parameter int unsigned W       = 3,           // Number of pins
  parameter logic [2:0]  IDLE    = 3'b111       // Level held during reset
) (
  input  wire logic         clk_i,              // System clock
  input  wire logic         reset_i,            // Async reset, active high
  input  wire logic [W-1:0] pin_i,              // Raw pin levels
  output logic      [W-1:0] sync_o              // Synchronised levels
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta_q;                         // First stage, read only by second

  // First and second stage; only sync_o leaves this module
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= IDLE[W-1:0];
      sync_o <= IDLE[W-1:0];
    end else begin
      meta_q <= pin_i;
      sync_o <= meta_q;
    end
  end

endmodule : sarctl_sync
`default_nettype wire

// File: dv/sarctl_host_model.sv
/*
  Host controller model: drives start, select and read strobes.
  Assumes the bench calls its tasks; pins move 5 ns after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sarctl_host_model (
  input  wire logic        clk_i,                // System clock
  input  wire logic [17:0] data_i,               // Parallel data seen
  input  wire logic        oe_n_i,               // Data enable, low drives
  output logic             conversion_start_n_o, // Start strobe, low active
  output logic             cs_n_o,               // Select, low active
  output logic             rd_n_o                // Read strobe, low active
);
  // Idle high; read strobe never parked low before trim
  initial begin
    conversion_start_n_o = 1'b1;
    cs_n_o               = 1'b1;
    rd_n_o               = 1'b1;
  end
  // Step n edges, then move off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask : tick
  // Start low one full cycle (50 ns, past 40 ns) with select low
  task automatic start_conv(input logic keep_cs);
    cs_n_o               = 1'b0;
    conversion_start_n_o = 1'b0;
    tick(1);
    conversion_start_n_o = 1'b1;
    tick(1);
    // Select held one more cycle so both levels line up at the sync
    cs_n_o = keep_cs ? 1'b0 : 1'b1;
  endtask : start_conv
  // Select falls from high
  task automatic select_fall();
    cs_n_o = 1'b1;
    tick(1);
    cs_n_o = 1'b0;
  endtask : select_fall
  // One full read strobe toggle, counted by the device
  task automatic read_word(input logic sel, output logic [17:0] d, output logic oe_n);
    cs_n_o = !sel;
    rd_n_o = 1'b0;
    tick(6);
    d      = data_i;
    oe_n   = oe_n_i;
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    tick(6);
  endtask : read_word
endmodule : sarctl_host_model
`default_nettype wire

// File: dv/sarctl_core_tb_top.sv
/*
  Self-checking bench for the converter control block.
  Assumes the host model drives the pins; sample_i stands in for the analog core.
*/
`timescale 1ns/1ps
`default_nettype none
module sarctl_core_tb_top;
  import sarctl_pkg::*;
  logic        clk;                 // 20 MHz clock
  logic        reset_i;             // Async reset, pulsed again mid-run
  logic [17:0] sample_i;            // Analog result, changed for the abort-start and reset-mid scenarios
  wire         st_n, cs_n, rd_n;    // Host pins
  logic        busy_o, acq_o, trim_ok_o, data_oe_n_o; // Status
  logic [17:0] data_o;              // Parallel data
  logic [17:0] d;                   // Captured read data
  logic        oe;                  // Captured enable
  int          n;                   // Cycle count
  int          bad_count = 0;       // Mismatches
  int          compares = 0;        // Comparisons

  always #25 clk = ~clk;

  sarctl_core sarctl_core_i (.clk_i(clk), .reset_i(reset_i), .conversion_start_n_i(st_n),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .sample_i(sample_i), .busy_o(busy_o), .acq_o(acq_o),
    .trim_ok_o(trim_ok_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o));
  sarctl_host_model sarctl_host_model_i (.clk_i(clk), .data_i(data_o), .oe_n_i(data_oe_n_o),
    .conversion_start_n_o(st_n), .cs_n_o(cs_n), .rd_n_o(rd_n));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl, input int max);
    n = 0;
    while (busy_o !== lvl && n < max) begin
      sarctl_host_model_i.tick(1);
      n++;
    end
  endtask : wait_busy
  // Full conversion; busy length checked against the conversion count
  task automatic run_conv();
    sarctl_host_model_i.start_conv(1'b0);
    wait_busy(1'b1, 8);
    check({17'h0, busy_o}, 18'h1);
    check({17'h0, acq_o}, 18'h0);
    wait_busy(1'b0, 40);
    check(18'(n), 18'(CONV_CYC));
    check({17'h0, acq_o}, 18'h1);
  endtask : run_conv

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_early();
    run_conv();
    sarctl_host_model_i.read_word(1'b1, d, oe);
    check(d, DATA_BAD);
    check({17'h0, oe}, 18'h0);
    sarctl_host_model_i.read_word(1'b1, d, oe);
    check({17'h0, trim_ok_o}, 18'h0);
    sarctl_host_model_i.read_word(1'b1, d, oe);
    sarctl_host_model_i.tick(4);
    check({17'h0, trim_ok_o}, 18'h1);
    $display("test early done");
  endtask : t_early
  task automatic t_normal();
    run_conv();
    sarctl_host_model_i.read_word(1'b1, d, oe);
    check(d, sample_i);
    sarctl_host_model_i.read_word(1'b0, d, oe);
    check({17'h0, oe}, 18'h1);
    $display("test normal done");
  endtask : t_normal
  // Select falls mid-conversion: self-clearing abort, latches zeroed
  task automatic t_abort_cs();
    sarctl_host_model_i.start_conv(1'b0);
    wait_busy(1'b1, 8);
    sarctl_host_model_i.tick(5);
    sarctl_host_model_i.select_fall();
    wait_busy(1'b0, 8);
    check({17'h0, n < 8}, 18'h1);
    sarctl_host_model_i.tick(3);
    check({17'h0, acq_o}, 18'h1);
    sarctl_host_model_i.read_word(1'b1, d, oe);
    check(d, DATA_RST);
    $display("test abort select done");
  endtask : t_abort_cs
  // Second start fall with select low mid-conversion
  task automatic t_abort_st();
    sample_i = 18'h1_5A3C;
    run_conv();
    sarctl_host_model_i.start_conv(1'b1);
    wait_busy(1'b1, 8);
    sarctl_host_model_i.tick(5);
    sarctl_host_model_i.start_conv(1'b1);
    wait_busy(1'b0, 8);
    check({17'h0, n < 8}, 18'h1);
    sarctl_host_model_i.tick(3);
    check({17'h0, busy_o}, 18'h0);
    check({17'h0, acq_o}, 18'h1);
    sarctl_host_model_i.read_word(1'b1, d, oe);
    check(d, DATA_RST);
    $display("test abort start done");
  endtask : t_abort_st
  // Reset in mid-conversion: trim count restarts, early result invalid again
  task automatic t_reset_mid();
    sample_i = 18'h0_3C96;
    sarctl_host_model_i.start_conv(1'b0);
    wait_busy(1'b1, 8);
    sarctl_host_model_i.tick(4);
    reset_i = 1'b1;
    sarctl_host_model_i.tick(2);
    check({17'h0, busy_o}, 18'h0);
    reset_i = 1'b0;
    sarctl_host_model_i.tick(1);
    check({14'h0, busy_o, acq_o, trim_ok_o, data_oe_n_o}, 18'h5);
    check(data_o, DATA_RST);
    run_conv();
    sarctl_host_model_i.read_word(1'b1, d, oe);
    check(d, DATA_BAD);
    repeat (2) sarctl_host_model_i.read_word(1'b1, d, oe);
    check({17'h0, trim_ok_o}, 18'h1);
    run_conv();
    sarctl_host_model_i.read_word(1'b1, d, oe);
    check(d, sample_i);
    $display("test reset mid done");
  endtask : t_reset_mid

  // ----------------------------------------------------------------
  // Closing and sequence
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Watchdog: tests need about 350 cycles, allow far more
  initial begin
    #100_000;
    bad_count++;
    summarize();
  end

  initial begin
    clk      = 1'b0;
    reset_i  = 1'b1;
    sample_i = 18'h2_A5C3;
    sarctl_host_model_i.tick(12);
    reset_i = 1'b0;
    sarctl_host_model_i.tick(1);
    check({14'h0, busy_o, acq_o, trim_ok_o, data_oe_n_o}, 18'h5);
    check(data_o, DATA_RST);
    t_early();
    t_normal();
    t_abort_cs();
    t_abort_st();
    t_reset_mid();
    summarize();
  end
endmodule : sarctl_core_tb_top
`default_nettype wire
